// >>> core/fcs_top.sv
// flash code security logic with apb register access
//
// Operation
// - in programming mode the security and id registers refuse reads and writes
// - a security bit cleared to zero stays zero until erase-all; here RST also reloads the erased value
// - security word sits at the top index of the loader flash space
// - lock bit zero refuses flash access and special register access
// - inhibit zero: table read from external code reaches external memory only
// - table read from internal code reaches internal and external memory
// - inhibit one: table reads are unrestricted
// - encryption enabled: port 0 data passes the encoder before the pins
// - security bit 7 zero halves the oscillator amplifier gain
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module fcs_top
  import fcs_pkg::*;
#(
  parameter logic [ID_W-1:0] MAKER_ID = 8'hA5, // arbitrary value
  parameter logic [ID_W-1:0] PART_ID  = 8'h3C, // arbitrary value
  parameter logic [P0_W-1:0] P0_KEY   = P0_KEY_DEF
)
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // programming mode pin (asynchronous)
  input  wire logic              PROG_MODE_PIN,
  // flash access from the programmer side
  input  wire logic              FLASH_ACC_REQ,
  output logic                   FLASH_ACC_GRANT,
  output logic                   FLASH_ACC_DENY,
  // code table read steering from the core
  input  wire logic              TBL_REQ,
  input  wire logic              TBL_FETCH_EXT,
  input  wire logic              TBL_TARGET_INT,
  output logic                   TBL_VALID,
  output logic                   TBL_USE_INT,
  output logic                   TBL_USE_EXT,
  // port 0 data path
  input  wire logic [P0_W-1:0]   P0_DATA,
  output logic      [P0_W-1:0]   P0_PINS,
  // oscillator gain control
  output logic                   OSC_HALF_GAIN
);

  // non-volatile security word image and status
  logic [SEC_W-1:0]  sec_r;
  logic [SEC_W-1:0]  sec_nxt;
  logic              refused_r;
  logic              refused_nxt;
  logic              prog_mode;
  logic [P0_W-1:0]   p0_coded;

  // decoded bus terms
  logic [IDX_W-1:0]  idx;
  logic              setup;
  logic              access;
  logic              wr_fire;
  logic              hit_sec;
  logic              hit_ctrl;
  logic              hit_stat;
  logic              hit_maker;
  logic              hit_part;
  logic              hit_special;
  logic              locked;
  fcs_acc_type       acc_kind;
  logic [DATA_W-1:0] rd_word;
  logic              acc_bad_r;
  logic              erase_req;
  logic              sec_wr_req;
  logic              clr_refuse;
  logic              flash_deny_now;

  // programming mode level from the pin
  fcs_sync u_prog_sync (
    .CLK      (CLK),
    .RST      (RST),
    .ASYNC_IN (PROG_MODE_PIN),
    .SYNC_OUT (prog_mode)
  );

  // port 0 encoder
  fcs_scramble #(
    .W   (P0_W),
    .KEY (P0_KEY)
  ) u_p0_scramble (
    .PLAIN (P0_DATA),
    .CODED (p0_coded)
  );

  // lock active when its bit reads zero
  assign locked = ~sec_r[SEC_LOCK];

  // apb phase and address decode
  assign idx         = PADDR[IDX_LSB +: IDX_W];
  assign setup       = PSEL & ~PENABLE;
  assign access      = PSEL & PENABLE & PREADY;
  assign hit_sec     = (idx == IDX_SEC);
  assign hit_ctrl    = (idx == IDX_CTRL);
  assign hit_stat    = (idx == IDX_STAT);
  assign hit_maker   = (idx == IDX_MAKER);
  assign hit_part    = (idx == IDX_PART);
  assign hit_special = hit_sec | hit_maker | hit_part;

  // classify the request during its setup cycle
  always_comb begin
    acc_kind = FCS_ACC_OK;
    if (!(hit_special | hit_ctrl | hit_stat)) begin
      acc_kind = FCS_ACC_UNMAP;
    end else if (hit_special && prog_mode) begin
      acc_kind = FCS_ACC_DENIED;
    end else if (hit_special && locked) begin
      acc_kind = FCS_ACC_DENIED;
    end else if (PWRITE && (hit_stat | hit_maker | hit_part)) begin
      acc_kind = FCS_ACC_RO;
    end
  end

  // read data mux; unused bits read zero
  always_comb begin
    rd_word = '0;
    if (hit_sec) begin
      rd_word[SEC_W-1:0] = sec_r;
    end else if (hit_stat) begin
      rd_word[STAT_PROG]    = prog_mode;
      rd_word[STAT_LOCKED]  = locked;
      rd_word[STAT_REFUSED] = refused_r;
      rd_word[STAT_ENCRYPT] = ~sec_r[SEC_ENCRYPT];
    end else if (hit_maker) begin
      rd_word[ID_W-1:0] = MAKER_ID;
    end else if (hit_part) begin
      rd_word[ID_W-1:0] = PART_ID;
    end
  end

  // no wait state: ready pulses in the first access cycle only
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  // refusal decision, kept for the write gate and the sticky flag
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_bad_r <= 1'b0;
    end else if (setup) begin
      acc_bad_r <= (acc_kind != FCS_ACC_OK);
    end
  end

  // error answer stands only with ready
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PSLVERR <= (acc_kind != FCS_ACC_OK);
    end else if (access) begin
      PSLVERR <= 1'b0;
    end
  end

  // read data stands only with ready; refused reads give zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (setup) begin
      PRDATA <= (!PWRITE && acc_kind == FCS_ACC_OK) ? rd_word : '0;
    end else if (access) begin
      PRDATA <= '0;
    end
  end

  // write takes effect at the completing edge only
  assign wr_fire    = access & PWRITE & ~acc_bad_r;
  assign erase_req  = wr_fire & hit_ctrl & PWDATA[CTRL_ERASE_ALL];
  assign clr_refuse = wr_fire & hit_ctrl & PWDATA[CTRL_CLR_REFUSE];
  assign sec_wr_req = wr_fire & hit_sec;

  // security word: bits only fall, erase-all restores them
  always_comb begin
    sec_nxt = sec_r;
    if (erase_req) begin
      sec_nxt = SEC_ERASED;
    end else if (sec_wr_req) begin
      sec_nxt = sec_r & PWDATA[SEC_W-1:0];
    end
  end

  // erased image after reset, like a blank part
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sec_r <= SEC_ERASED;
    end else begin
      sec_r <= sec_nxt;
    end
  end

  // flash access gate for the programmer side
  assign flash_deny_now = FLASH_ACC_REQ & locked;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FLASH_ACC_GRANT <= 1'b0;
    end else begin
      FLASH_ACC_GRANT <= FLASH_ACC_REQ & ~locked;
    end
  end

  // deny follows the request while the lock reads zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FLASH_ACC_DENY <= 1'b0;
    end else begin
      FLASH_ACC_DENY <= flash_deny_now;
    end
  end

  // sticky refusal flag; a new refusal beats the clear
  always_comb begin
    refused_nxt = refused_r;
    if (clr_refuse) begin
      refused_nxt = 1'b0;
    end
    if (flash_deny_now || (access && acc_bad_r && hit_special)) begin
      refused_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= refused_nxt;
    end
  end

  // table answer valid one cycle after the request
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TBL_VALID <= 1'b0;
    end else begin
      TBL_VALID <= TBL_REQ;
    end
  end

  // code table read steering
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TBL_USE_INT <= 1'b0;
      TBL_USE_EXT <= 1'b0;
    end else begin
      if (!TBL_REQ) begin
        TBL_USE_INT <= 1'b0;
        TBL_USE_EXT <= 1'b0;
      end else if (!TBL_TARGET_INT) begin
        TBL_USE_INT <= 1'b0;
        TBL_USE_EXT <= 1'b1;
      end else if (sec_r[SEC_INHIBIT]) begin
        TBL_USE_INT <= 1'b1;
        TBL_USE_EXT <= 1'b0;
      end else if (!TBL_FETCH_EXT) begin
        TBL_USE_INT <= 1'b1;
        TBL_USE_EXT <= 1'b0;
      end else begin
        TBL_USE_INT <= 1'b0;
        TBL_USE_EXT <= 1'b1;
      end
    end
  end

  // port 0 output, encoded when encryption bit reads zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      P0_PINS <= '0;
    end else if (!sec_r[SEC_ENCRYPT]) begin
      P0_PINS <= p0_coded;
    end else begin
      P0_PINS <= P0_DATA;
    end
  end

  // oscillator gain halves when bit 7 reads zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OSC_HALF_GAIN <= 1'b0;
    end else begin
      OSC_HALF_GAIN <= ~sec_r[SEC_OSCGAIN];
    end
  end

endmodule : fcs_top

// >>> include/fcs_pkg.sv
// constants for the flash code security logic
package fcs_pkg;

  // apb bus shape
  localparam int unsigned ADDR_W          = 18;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned IDX_W           = 16;
  localparam int unsigned IDX_LSB         = 2;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SEC         = 16'hFFFF;
  localparam logic [15:0] IDX_CTRL        = 16'h0000;
  localparam logic [15:0] IDX_STAT        = 16'h0001;
  localparam logic [15:0] IDX_MAKER       = 16'h0002;
  localparam logic [15:0] IDX_PART        = 16'h0003;

  // security word layout and erased value
  localparam int unsigned SEC_W           = 8;
  localparam int unsigned SEC_LOCK        = 0;
  localparam int unsigned SEC_INHIBIT     = 1;
  localparam int unsigned SEC_ENCRYPT     = 2;
  localparam int unsigned SEC_OSCGAIN     = 7;
  localparam logic [7:0]  SEC_ERASED      = 8'hFF;

  // control register bits (write one to act)
  localparam int unsigned CTRL_ERASE_ALL  = 0;
  localparam int unsigned CTRL_CLR_REFUSE = 1;

  // status register bits
  localparam int unsigned STAT_PROG       = 0;
  localparam int unsigned STAT_LOCKED     = 1;
  localparam int unsigned STAT_REFUSED    = 2;
  localparam int unsigned STAT_ENCRYPT    = 3;

  // identification registers are eight bits wide
  localparam int unsigned ID_W            = 8;

  // port 0 width and scramble key default (arbitrary value)
  localparam int unsigned P0_W            = 8;
  localparam logic [7:0]  P0_KEY_DEF      = 8'h5A;

  // apb answer kinds
  typedef enum logic [1:0] {
    FCS_ACC_OK     = 2'b00,
    FCS_ACC_UNMAP  = 2'b01,
    FCS_ACC_DENIED = 2'b10,
    FCS_ACC_RO     = 2'b11
  } fcs_acc_type;

endpackage : fcs_pkg

// >>> core/fcs_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module fcs_sync
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // async level in, clean level out
  input  wire logic ASYNC_IN,
  output logic      SYNC_OUT
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // shift chain; first stage feeds only the second
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= ASYNC_IN;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // level changes once stages two and three agree
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SYNC_OUT <= 1'b0;
    end else if (stage2_r == stage3_r) begin
      SYNC_OUT <= stage3_r;
    end
  end

endmodule : fcs_sync

// >>> core/fcs_scramble.sv
// port 0 data encoder: rotate by one and mix with a key
`timescale 1ns/1ns
module fcs_scramble
  import fcs_pkg::*;
#(
  parameter int unsigned          W   = P0_W,
  parameter logic [P0_W-1:0]      KEY = P0_KEY_DEF
)
(
  // plain and encoded data
  input  wire logic [W-1:0] PLAIN,
  output logic      [W-1:0] CODED
);

  // each output bit takes its neighbour xor a key bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign CODED[i] = PLAIN[(i + 1) % W] ^ KEY[i];
  end

endmodule : fcs_scramble

// >>> testbench/fcs_top_props.sv
// port checker for the flash code security logic
`timescale 1ns/1ns
module fcs_top_chk
  import fcs_pkg::*;
#(
  parameter logic [P0_W-1:0] P0_KEY = P0_KEY_DEF
)
(
  // clock and reset
  input wire logic              CLK,
  input wire logic              RST,
  // apb answer side
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PREADY,
  input wire logic [DATA_W-1:0] PRDATA,
  // flash gate
  input wire logic              FLASH_ACC_REQ,
  input wire logic              FLASH_ACC_GRANT,
  input wire logic              FLASH_ACC_DENY,
  // table read steering
  input wire logic              TBL_REQ,
  input wire logic              TBL_FETCH_EXT,
  input wire logic              TBL_TARGET_INT,
  input wire logic              TBL_VALID,
  input wire logic              TBL_USE_INT,
  input wire logic              TBL_USE_EXT,
  // port 0
  input wire logic [P0_W-1:0]   P0_DATA,
  input wire logic [P0_W-1:0]   P0_PINS
);
  logic [P0_W-1:0] p0_q_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // port 0 data one cycle back
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) p0_q_r <= '0;
    else     p0_q_r <= P0_DATA;
  end
  a_ready_once: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready is not a single pulse");
  a_data_idle: assert property (!PREADY |-> PRDATA == '0)
    else $error("read data outside access");
  a_gate_follow: assert property ((FLASH_ACC_GRANT || FLASH_ACC_DENY) == $past(FLASH_ACC_REQ))
    else $error("flash gate does not follow request");
  a_gate_excl: assert property (!(FLASH_ACC_GRANT && FLASH_ACC_DENY))
    else $error("grant and deny together");
  a_tbl_ext: assert property (TBL_REQ && !TBL_TARGET_INT |=> TBL_VALID && TBL_USE_EXT && !TBL_USE_INT)
    else $error("external table target misrouted");
  a_tbl_int: assert property (TBL_REQ && TBL_TARGET_INT && !TBL_FETCH_EXT |=> TBL_USE_INT && !TBL_USE_EXT)
    else $error("internal fetch lost internal reach");
  a_tbl_route: assert property (TBL_VALID |-> TBL_USE_INT ^ TBL_USE_EXT)
    else $error("table read not routed to one memory");
  a_p0_form: assert property (P0_PINS == p0_q_r || P0_PINS == ({p0_q_r[0], p0_q_r[7:1]} ^ P0_KEY))
    else $error("port 0 pins neither plain nor encoded");
endmodule : fcs_top_chk

bind fcs_top fcs_top_chk #(.P0_KEY(P0_KEY)) chk_u (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PRDATA(PRDATA),
  .FLASH_ACC_REQ(FLASH_ACC_REQ), .FLASH_ACC_GRANT(FLASH_ACC_GRANT), .FLASH_ACC_DENY(FLASH_ACC_DENY),
  .TBL_REQ(TBL_REQ), .TBL_FETCH_EXT(TBL_FETCH_EXT), .TBL_TARGET_INT(TBL_TARGET_INT),
  .TBL_VALID(TBL_VALID), .TBL_USE_INT(TBL_USE_INT), .TBL_USE_EXT(TBL_USE_EXT),
  .P0_DATA(P0_DATA), .P0_PINS(P0_PINS));

// >>> testbench/fcs_prog_model.sv
// programmer model: mode pin and flash access requests
`timescale 1ns/1ns
module fcs_prog_model (
  // clock
  input  wire logic CLK,
  // commands from the bench
  input  wire logic prog_on,
  input  wire logic acc_on,
  // pins toward the device
  output logic      PROG_MODE_PIN = 1'b0,
  output logic      FLASH_ACC_REQ = 1'b0
);
  // pins change just after an edge, only when told
  always @(posedge CLK) begin
    PROG_MODE_PIN <= prog_on;
    FLASH_ACC_REQ <= acc_on;
  end
endmodule : fcs_prog_model

// >>> testbench/tb.sv
// bench for the flash code security logic
`timescale 1ns/1ns
module tb;
  import fcs_pkg::*;
  localparam logic [ADDR_W-1:0] A_SEC = {IDX_SEC, 2'b00};
  localparam logic [ADDR_W-1:0] A_MAK = {IDX_MAKER, 2'b00};
  localparam logic [ADDR_W-1:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_STA = {IDX_STAT, 2'b00};
  logic              clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              prog_on, acc_on, prog_pin, acc_req, grant, deny;
  logic              treq, text, tint, tvalid, use_int, use_ext, half;
  logic [P0_W-1:0]   p0_data, p0_pins;
  int                miscompares, cmp_count, cyc;
  // device and programmer
  fcs_top dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PROG_MODE_PIN(prog_pin), .FLASH_ACC_REQ(acc_req), .FLASH_ACC_GRANT(grant),
    .FLASH_ACC_DENY(deny), .TBL_REQ(treq), .TBL_FETCH_EXT(text), .TBL_TARGET_INT(tint),
    .TBL_VALID(tvalid), .TBL_USE_INT(use_int), .TBL_USE_EXT(use_ext), .P0_DATA(p0_data),
    .P0_PINS(p0_pins), .OSC_HALF_GAIN(half));
  fcs_prog_model prog_u (.CLK(clk), .prog_on(prog_on), .acc_on(acc_on),
    .PROG_MODE_PIN(prog_pin), .FLASH_ACC_REQ(acc_req));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic wrap_up;
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one apb transfer with expected read data and error flag
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk(prdata, ed);
    chk({31'h0, pslverr}, {31'h0, ee});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one table read with expected routing
  task automatic tbl(input logic fe, input logic ti, input logic ei, input logic ee);
    @(posedge clk);
    treq <= 1'b1;
    text <= fe;
    tint <= ti;
    @(posedge clk);
    treq <= 1'b0;
    @(negedge clk);
    chk({30'h0, use_int, use_ext}, {30'h0, ei, ee});
  endtask : tbl
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    {rst, psel, penable, pwrite, treq, text, tint, prog_on, acc_on} = 9'h100;
    {paddr, pwdata, p0_data} = '0;
    {miscompares, cmp_count, cyc} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_SEC, 32'h0, 32'h0000_00FF, 1'b0);
    apb(1'b0, 18'h0_0010, 32'h0, 32'h0, 1'b1);
    chk({31'h0, half}, 32'h0);
    tbl(1'b1, 1'b1, 1'b1, 1'b0);
    apb(1'b1, A_SEC, 32'h0000_007F, 32'h0, 1'b0);
    apb(1'b1, A_SEC, 32'h0000_00FF, 32'h0, 1'b0);
    apb(1'b0, A_SEC, 32'h0, 32'h0000_007F, 1'b0);
    chk({31'h0, half}, 32'h0000_0001);
    apb(1'b1, A_SEC, 32'h0000_00FD, 32'h0, 1'b0);
    tbl(1'b1, 1'b1, 1'b0, 1'b1);
    tbl(1'b0, 1'b1, 1'b1, 1'b0);
    tbl(1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    p0_data <= 8'h81;
    repeat (2) @(negedge clk);
    chk({24'h0, p0_pins}, 32'h0000_0081);
    apb(1'b1, A_SEC, 32'h0000_00FB, 32'h0, 1'b0);
    repeat (2) @(negedge clk);
    chk({24'h0, p0_pins}, 32'h0000_009A);
    @(posedge clk);
    prog_on <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, A_SEC, 32'h0, 32'h0, 1'b1);
    apb(1'b1, A_SEC, 32'h0000_0000, 32'h0, 1'b1);
    apb(1'b0, A_MAK, 32'h0, 32'h0, 1'b1);
    apb(1'b0, A_STA, 32'h0, 32'h0000_000D, 1'b0);
    prog_on <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, A_SEC, 32'h0, 32'h0000_0079, 1'b0);
    apb(1'b1, A_MAK, 32'h0000_00FF, 32'h0, 1'b1);
    acc_on <= 1'b1;
    repeat (3) @(negedge clk);
    chk({30'h0, grant, deny}, 32'h0000_0002);
    apb(1'b1, A_SEC, 32'h0000_00FE, 32'h0, 1'b0);
    repeat (3) @(negedge clk);
    chk({30'h0, grant, deny}, 32'h0000_0001);
    apb(1'b0, A_SEC, 32'h0, 32'h0, 1'b1);
    apb(1'b0, A_MAK, 32'h0, 32'h0, 1'b1);
    apb(1'b0, A_STA, 32'h0, 32'h0000_000E, 1'b0);
    apb(1'b1, A_CTL, 32'h0000_0002, 32'h0, 1'b0);
    apb(1'b0, A_STA, 32'h0, 32'h0000_000E, 1'b0);
    apb(1'b1, A_CTL, 32'h0000_0001, 32'h0, 1'b0);
    apb(1'b0, A_SEC, 32'h0, 32'h0000_00FF, 1'b0);
    repeat (3) @(negedge clk);
    chk({30'h0, grant, deny}, 32'h0000_0002);
    apb(1'b1, A_CTL, 32'h0000_0002, 32'h0, 1'b0);
    apb(1'b0, A_STA, 32'h0, 32'h0000_0000, 1'b0);
    wrap_up();
  end
endmodule : tb
